// *** inc/lin_mode_pkg.sv ***
// Constants and types shared by the LIN mode control block
package lin_mode_pkg;
  localparam int unsigned CLK_MHZ = 100;

  // Register addresses on the plain register port
  localparam logic [2:0] ADDR_CTRL3    = 3'h0;
  localparam logic [2:0] ADDR_CTRL2    = 3'h1;
  localparam logic [2:0] ADDR_BAUD     = 3'h2;
  localparam logic [2:0] ADDR_EXT_PRE  = 3'h3;
  localparam logic [2:0] ADDR_LIN_INT  = 3'h4;
  localparam logic [2:0] ADDR_LIN_FRAC = 3'h5;
  localparam logic [2:0] ADDR_STATUS   = 3'h6;

  // Control register three bit positions
  localparam int unsigned BIT_DEFER  = 7;
  localparam int unsigned BIT_ENABLE = 6;
  localparam int unsigned BIT_SLAVE  = 5;
  localparam int unsigned BIT_ASYNC  = 4;
  localparam int unsigned BIT_HDM    = 3;
  localparam logic [7:0]  CTRL3_WMASK = 8'hf8;

  // Control register two bit positions
  localparam int unsigned BIT_MUTE = 1;
  localparam int unsigned BIT_SBK  = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_FRAC = 4'h0;

  // Break bit counts on the line and reference clocks per bit time
  localparam logic [3:0] MASTER_BREAK_BITS = 4'hd;
  localparam logic [3:0] SLAVE_BREAK_BITS  = 4'hb;
  localparam logic [7:0] BIT_PRESCALE      = 8'h10;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_MASTER,
    MODE_SLAVE
  } lin_mode_t;

  typedef enum {
    TX_IDLE,
    TX_BREAK
  } tx_state_t;
endpackage

// *** inc/lin_bit_if.sv ***
// Bit-time tick and line-level carrier between top and break counter
`timescale 1ns/100ps
`default_nettype none
interface lin_bit_if;
  logic       tick;
  logic       clear;
  logic       level_low;
  logic [3:0] target;
  logic       reached;
  modport ctl (output tick, output clear, output level_low, output target, input reached);
  modport cnt (input tick, input clear, input level_low, input target, output reached);
endinterface
`default_nettype wire

// *** src/lin_low_counter.sv ***
// Counts consecutive low bit times and flags a target count
`timescale 1ns/100ps
`default_nettype none
module lin_low_counter
  import lin_mode_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Control
  lin_bit_if.cnt    bus
);
  logic [3:0] count_q;
  logic [3:0] count_d;
  wire        at_target = (count_q >= bus.target);

  always_comb
  begin
    count_d = count_q;
    if (bus.clear)
      count_d = 4'h0;
    else if (bus.tick)
      count_d = bus.level_low ? (at_target ? count_q : count_q + 4'h1) : 4'h0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_q <= 4'h0;
    else
      count_q <= count_d;
  end

  assign bus.reached = at_target;
endmodule
`default_nettype wire

// *** src/lin_mode_control.sv ***
// LIN mode control, divider update, break send and break detect
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module lin_mode_control
  import lin_mode_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  // Receiver and sync-unit events
  input  wire logic       i_rx_full,
  input  wire logic       i_id_detect,
  input  wire logic       i_parity_enable,
  input  wire logic       i_async_upd,
  input  wire logic [7:0] i_async_int,
  input  wire logic [3:0] i_async_frac,
  // Line
  input  wire logic       i_rx_pin,
  output var  logic       o_tx_pin,
  // Status to the serial core
  output var  logic [7:0] o_lin_divider_int,
  output var  logic [3:0] o_lin_divider_frac,
  output var  logic       o_slave_gen_en,
  output var  logic       o_header_mgmt_en,
  output var  logic       o_parity_check_en,
  output var  logic       o_lin_wakeup_sel,
  output var  logic       o_break_detect,
  output var  logic       o_discard_rx,
  output var  logic       o_receiver_mute
);
  lin_bit_if tx_if ();
  lin_bit_if rx_if ();

  // Registers
  logic [7:0] ctrl3_q;
  logic [7:0] ctrl3_d;
  logic       mute_q;
  logic       sbk_q;
  logic [7:0] pre_int_q;
  logic [3:0] pre_frac_q;
  logic [7:0] div_int_q;
  logic [3:0] div_frac_q;
  logic       pend_q;
  logic       rx_s1_q;
  logic       rx_s2_q;
  logic [7:0] tick_cnt_q;
  logic       hunting_q;
  logic       brk_seen_q;
  logic       tx_pin_q;
  logic [7:0] rdata_q;
  tx_state_t  tx_state_q;
  tx_state_t  tx_state_d;

  // Mode decode
  lin_mode_t mode;
  assign mode = !ctrl3_q[BIT_ENABLE] ? MODE_OFF :
                (ctrl3_q[BIT_SLAVE] ? MODE_SLAVE : MODE_MASTER);
  wire is_slave  = (mode == MODE_SLAVE);
  wire is_master = (mode == MODE_MASTER);
  wire defer_on  = is_slave && ctrl3_q[BIT_DEFER];
  wire async_on  = is_slave && ctrl3_q[BIT_ASYNC];
  wire hdm_on    = is_slave && ctrl3_q[BIT_HDM];

  // Write decode; slave maps prescalers onto baud and extended addresses
  wire wr_ctrl3 = i_wr && (i_addr == ADDR_CTRL3);
  wire wr_ctrl2 = i_wr && (i_addr == ADDR_CTRL2);
  wire wr_int   = i_wr && ((i_addr == ADDR_LIN_INT) || (is_slave && i_addr == ADDR_BAUD));
  wire wr_frac  = i_wr && ((i_addr == ADDR_LIN_FRAC) || (is_slave && i_addr == ADDR_EXT_PRE));
  wire rx_set   = i_rx_full;

  // Divider load: auto-sync wins, then immediate write, then deferred reload
  wire async_load = async_on && i_async_upd;
  wire imm_int    = wr_int && !defer_on && !async_load;
  wire imm_frac   = wr_frac && !defer_on && !async_load;
  wire defer_load = defer_on && rx_set && !async_load;

  // Next control three: hardware clear of update bit on receive-full
  always_comb
  begin
    ctrl3_d = ctrl3_q;
    if (wr_ctrl3)
      ctrl3_d = i_wdata & CTRL3_WMASK;
    if (rx_set && ctrl3_q[BIT_ENABLE] && ctrl3_q[BIT_SLAVE])
      ctrl3_d[BIT_DEFER] = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl3_q    <= RESET_BYTE;
      mute_q     <= 1'b0;
      sbk_q      <= 1'b0;
      pre_int_q  <= RESET_BYTE;
      pre_frac_q <= RESET_FRAC;
      pend_q     <= 1'b0;
    end
    else
    begin
      ctrl3_q <= ctrl3_d;
      if (wr_ctrl2)
        sbk_q <= i_wdata[BIT_SBK];
      // Mute write refused in slave mode while a character waits
      if (wr_ctrl2 && !(is_slave && rx_set))
        mute_q <= i_wdata[BIT_MUTE];
      else if (mute_q && o_break_detect && !hdm_on)
        mute_q <= 1'b0;
      else if (mute_q && is_slave && hdm_on && i_id_detect)
        mute_q <= 1'b0;
      if (wr_int)
        pre_int_q <= i_wdata;
      if (wr_frac)
        pre_frac_q <= i_wdata[3:0];
      // A staged integer write waits for the next character
      if (wr_int && defer_on)
        pend_q <= 1'b1;
      else if (defer_load)
        pend_q <= 1'b0;
    end
  end

  // Divider holding register
  // Immediate writes reach the divider one cycle after the strobe; deferred writes wait for receive-full
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_int_q  <= RESET_BYTE;
      div_frac_q <= RESET_FRAC;
    end
    else if (async_load)
    begin
      div_int_q  <= i_async_int;
      div_frac_q <= i_async_frac;
    end
    else
    begin
      if (imm_int)
        div_int_q <= i_wdata;
      if (imm_frac)
        div_frac_q <= i_wdata[3:0];
      if (defer_load)
      begin
        div_int_q  <= pre_int_q;
        div_frac_q <= pre_frac_q;
      end
    end
  end

  // Line input synchroniser and bit-time tick
  // Idle-high reset keeps a false low run from following reset
  wire tick = (tick_cnt_q == BIT_PRESCALE - 8'h1);
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_s1_q    <= 1'b1;
      rx_s2_q    <= 1'b1;
      tick_cnt_q <= 8'h0;
    end
    else
    begin
      rx_s1_q    <= i_rx_pin;
      rx_s2_q    <= rx_s1_q;
      tick_cnt_q <= tick ? 8'h0 : tick_cnt_q + 8'h1;
    end
  end

  // Break detection in slave mode
  // Counter held clear outside slave mode
  assign rx_if.tick      = tick;
  assign rx_if.clear     = !is_slave;
  assign rx_if.level_low = !rx_s2_q;
  assign rx_if.target    = SLAVE_BREAK_BITS;
  lin_low_counter u_rx_cnt (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bus       (rx_if)
  );

  // Break transmit in master mode
  assign tx_if.tick      = tick;
  assign tx_if.clear     = (tx_state_q == TX_IDLE);
  assign tx_if.level_low = 1'b1;
  // Entry tick opens bit one; leave on the tick after twelve counted
  assign tx_if.target    = MASTER_BREAK_BITS - 4'h1;
  lin_low_counter u_tx_cnt (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bus       (tx_if)
  );

  always_comb
  begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TX_IDLE:
        if (is_master && sbk_q && tick)
          tx_state_d = TX_BREAK;
      TX_BREAK:
        if (tick && tx_if.reached)
          tx_state_d = TX_IDLE;
      default:
        tx_state_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_state_q <= TX_IDLE;
      tx_pin_q   <= 1'b1;
      hunting_q  <= 1'b0;
      brk_seen_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_pin_q   <= (tx_state_d != TX_BREAK);
      brk_seen_q <= is_slave && rx_if.reached;
      // Discard starts at a mute write in slave mode and ends at a break
      if (is_slave && wr_ctrl2 && !rx_set)
        hunting_q <= i_wdata[BIT_MUTE];
      else if (!(is_slave && mute_q))
        hunting_q <= 1'b0;
      else if (rx_if.reached)
        hunting_q <= 1'b0;
    end
  end

  // Read path
  // Zero outside the cycle after a read strobe
  wire [7:0] ctrl2_rd = {6'h0, mute_q, sbk_q};
  wire [7:0] stat_rd  = {5'h0, pend_q, brk_seen_q, tx_state_q == TX_BREAK};
  wire [7:0] rd_mux   =
    (i_addr == ADDR_CTRL3)                 ? ctrl3_q :
    (i_addr == ADDR_CTRL2)                 ? ctrl2_rd :
    (i_addr == ADDR_LIN_INT)               ? pre_int_q :
    (i_addr == ADDR_LIN_FRAC)              ? {4'h0, pre_frac_q} :
    (is_slave && i_addr == ADDR_BAUD)      ? pre_int_q :
    (is_slave && i_addr == ADDR_EXT_PRE)   ? {4'h0, pre_frac_q} :
    (i_addr == ADDR_STATUS)                ? stat_rd : 8'h00;

  // Mode levels leave flops one cycle after the mode changes
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q            <= RESET_BYTE;
      o_slave_gen_en     <= 1'b0;
      o_header_mgmt_en   <= 1'b0;
      o_parity_check_en  <= 1'b0;
      o_lin_wakeup_sel   <= 1'b0;
    end
    else
    begin
      rdata_q            <= i_rd ? rd_mux : 8'h00;
      o_slave_gen_en     <= is_slave;
      o_header_mgmt_en   <= is_slave;
      o_parity_check_en  <= is_slave && i_parity_enable;
      o_lin_wakeup_sel   <= hdm_on;
    end
  end

  // Every output comes straight from a flop
  assign o_rdata            = rdata_q;
  assign o_tx_pin           = tx_pin_q;
  assign o_lin_divider_int  = div_int_q;
  assign o_lin_divider_frac = div_frac_q;
  assign o_break_detect     = brk_seen_q;
  assign o_discard_rx       = hunting_q;
  assign o_receiver_mute    = mute_q;
endmodule
`default_nettype wire

// *** bench/lin_mode_asserts.sv ***
// Port assertions for the LIN mode control block
`timescale 1ns/100ps
`default_nettype none
module lin_mode_asserts
  import lin_mode_pkg::*;
(
  // Clock, reset, inputs
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_rx_full,
  input wire logic       i_async_upd,
  input wire logic       i_parity_enable,
  input wire logic       i_rx_pin,
  // Outputs
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_lin_divider_int,
  input wire logic       o_tx_pin,
  input wire logic       o_slave_gen_en,
  input wire logic       o_header_mgmt_en,
  input wire logic       o_parity_check_en,
  input wire logic       o_lin_wakeup_sel,
  input wire logic       o_break_detect,
  input wire logic       o_discard_rx,
  input wire logic       o_receiver_mute
);
  localparam int BRK_CYC = int'(MASTER_BREAK_BITS) * int'(BIT_PRESCALE);
  int low_q;
  // Length of the current low stretch on the transmit line
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      low_q <= 0;
    else
      low_q <= o_tx_pin ? 0 : low_q + 1;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_DIV_CAUSE: assert property (!$stable(o_lin_divider_int) |-> $past(i_wr) || $past(i_rx_full) || $past(i_async_upd))
    else $error("divider changed without cause");
  AST_GEN_HDR: assert property (o_slave_gen_en == o_header_mgmt_en)
    else $error("generator and header enables differ");
  AST_PARITY: assert property (o_parity_check_en |-> $past(i_parity_enable) && o_slave_gen_en)
    else $error("parity check outside slave");
  AST_WAKE: assert property (o_lin_wakeup_sel |-> o_slave_gen_en)
    else $error("wake-up select outside slave");
  AST_NO_BRK: assert property (o_slave_gen_en |-> o_tx_pin)
    else $error("break sent in slave mode");
  AST_BRK_LEN: assert property ($rose(o_tx_pin) |-> low_q > 0 && low_q % BRK_CYC == 0)
    else $error("break length wrong");
  AST_DET: assert property ($rose(o_break_detect) |-> o_slave_gen_en && !$past(i_rx_pin))
    else $error("break detect without low line");
  AST_DISCARD: assert property ($fell(o_discard_rx) |-> o_break_detect || !o_slave_gen_en || !o_receiver_mute)
    else $error("discard ended without break");
endmodule
`default_nettype wire

// *** bench/lin_node_model.sv ***
// Far-side LIN node that drives break pulses
`timescale 1ns/100ps
`default_nettype none
module lin_node_model
  import lin_mode_pkg::*;
(
  // Clock and command
  input  wire logic       i_ref_clk,
  input  wire logic       i_send,
  input  wire logic [4:0] i_bits,
  // Bus line
  output var  logic       o_line
);
  int cnt_q = 0;
  always @(posedge i_ref_clk)
    if (i_send)
      cnt_q <= int'(i_bits) * int'(BIT_PRESCALE);
    else if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
  // Dominant while counting, pull-up otherwise
  assign o_line = (cnt_q == 0);
endmodule
`default_nettype wire

// *** bench/lin_mode_control_bench.sv ***
// Testbench for the LIN mode control block
`timescale 1ns/100ps
`default_nettype none
module lin_mode_control_bench
  import lin_mode_pkg::*;
;
  logic       i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_rx_full = 1'b0;
  logic       i_parity_enable = 1'b1, i_async_upd = 1'b0, i_rx_pin, send = 1'b0, s, pe, i_id_detect = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [4:0] nbits = 5'h00;
  logic [7:0] i_wdata = 8'h00, i_async_int = 8'h00, v, o_rdata, o_lin_divider_int;
  logic [3:0] o_lin_divider_frac, i_async_frac = 4'h0;
  logic       o_tx_pin, o_slave_gen_en, o_header_mgmt_en, o_parity_check_en;
  logic       o_lin_wakeup_sel, o_break_detect, o_discard_rx, o_receiver_mute;
  int         n_mismatch = 0, num_checks = 0, seed = 5, m_div = 0, lowc = 0, k;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
    lowc <= o_tx_pin ? 0 : lowc + 1;
  lin_mode_control dut_u (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx_full, .i_id_detect, .i_parity_enable, .i_async_upd, .i_async_int, .i_async_frac,
    .i_rx_pin, .o_tx_pin, .o_lin_divider_int, .o_lin_divider_frac, .o_slave_gen_en, .o_header_mgmt_en,
    .o_parity_check_en, .o_lin_wakeup_sel, .o_break_detect, .o_discard_rx, .o_receiver_mute);
  lin_node_model node_u (.i_ref_clk, .i_send(send), .i_bits(nbits), .o_line(i_rx_pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d, input logic up);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_async_upd <= up;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_async_upd <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic pulse(input logic [4:0] b);
    @(posedge i_ref_clk);
    nbits <= b;
    send <= b != 5'h00;
    i_rx_full <= b == 5'h00;
    @(posedge i_ref_clk);
    send <= 1'b0;
    i_rx_full <= 1'b0;
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd_chk(ADDR_CTRL3, 8'h00);
    chk(8'(o_tx_pin), 8'h01);
    for (k = 0; k < 8; k++)
    begin
      v = (8'($random(seed)) & 8'h18) | {1'b0, k[1:0], 5'h00};
      s = v[6] & v[5];
      pe = 1'($random(seed));
      @(posedge i_ref_clk);
      i_parity_enable <= pe;
      wr_reg(ADDR_CTRL3, v, 1'b0);
      tick();
      chk(8'(o_slave_gen_en), 8'(s));
      chk(8'(o_header_mgmt_en), 8'(s));
      chk(8'(o_lin_wakeup_sel), 8'(s & v[3]));
      chk(8'(o_parity_check_en), 8'(s & pe));
      rd_chk(ADDR_CTRL3, v);
    end
    $display("mode test done");
    wr_reg(ADDR_CTRL3, 8'hc0, 1'b0);
    m_div = $random(seed) & 255;
    wr_reg(ADDR_LIN_INT, 8'(m_div), 1'b0);
    chk(o_lin_divider_int, 8'(m_div));
    wr_reg(ADDR_CTRL3, 8'he0, 1'b0);
    v = 8'($random(seed));
    wr_reg(ADDR_LIN_INT, v, 1'b0);
    chk(o_lin_divider_int, 8'(m_div));
    pulse(5'h00);
    m_div = v;
    chk(o_lin_divider_int, 8'(m_div));
    rd_chk(ADDR_CTRL3, 8'h60);
    wr_reg(ADDR_CTRL3, 8'he0, 1'b0);
    pulse(5'h00);
    chk(o_lin_divider_int, 8'(m_div));
    wr_reg(ADDR_CTRL3, 8'he0, 1'b0);
    wr_reg(ADDR_CTRL3, 8'h60, 1'b0);
    v = 8'($random(seed));
    wr_reg(ADDR_BAUD, v, 1'b0);
    chk(o_lin_divider_int, v);
    wr_reg(ADDR_EXT_PRE, ~v, 1'b0);
    chk(8'(o_lin_divider_frac), {4'h0, ~v[3:0]});
    rd_chk(ADDR_LIN_FRAC, {4'h0, ~v[3:0]});
    rd_chk(ADDR_LIN_INT, v);
    wr_reg(ADDR_CTRL3, 8'h70, 1'b0);
    i_async_int <= ~v;
    i_async_frac <= v[7:4];
    wr_reg(ADDR_LIN_INT, v ^ 8'h0f, 1'b1);
    chk(o_lin_divider_int, ~v);
    chk(8'(o_lin_divider_frac), {4'h0, v[7:4]});
    $display("divider test done");
    wr_reg(ADDR_CTRL3, 8'h40, 1'b0);
    wr_reg(ADDR_CTRL2, 8'h01, 1'b0);
    for (k = 0; k < 40 && o_tx_pin !== 1'b0; k++)
      tick();
    wr_reg(ADDR_CTRL2, 8'h00, 1'b0);
    for (k = 0; k < 400 && o_tx_pin !== 1'b1; k++)
      tick();
    chk(8'(lowc), 8'hd0);
    wr_reg(ADDR_CTRL3, 8'h60, 1'b0);
    wr_reg(ADDR_CTRL2, 8'h01, 1'b0);
    repeat (40) tick();
    chk(8'(o_tx_pin), 8'h01);
    $display("break send test done");
    wr_reg(ADDR_CTRL2, 8'h02, 1'b0);
    tick();
    chk(8'(o_discard_rx), 8'h01);
    pulse(5'h09);
    repeat (230) tick();
    chk(8'(o_break_detect), 8'h00);
    chk(8'(o_discard_rx), 8'h01);
    pulse(5'h0d);
    for (k = 0; k < 300 && o_break_detect !== 1'b1; k++)
      tick();
    chk(8'(o_break_detect), 8'h01);
    repeat (2) tick();
    chk(8'(o_discard_rx), 8'h00);
    chk(8'(o_receiver_mute), 8'h00);
    wr_reg(ADDR_CTRL3, 8'h68, 1'b0);
    wr_reg(ADDR_CTRL2, 8'h02, 1'b0);
    tick();
    chk(8'(o_receiver_mute), 8'h01);
    @(posedge i_ref_clk);
    i_id_detect <= 1'b1;
    @(posedge i_ref_clk);
    i_id_detect <= 1'b0;
    #1;
    chk(8'(o_receiver_mute), 8'h00);
    $display("break detect test done");
    close_out();
  end
endmodule
bind lin_mode_control lin_mode_asserts asserts_u (.i_ref_clk, .i_rst_n, .i_wr, .i_rd, .i_rx_full, .i_async_upd,
  .i_parity_enable, .i_rx_pin, .o_rdata, .o_lin_divider_int, .o_tx_pin, .o_slave_gen_en, .o_header_mgmt_en,
  .o_parity_check_en, .o_lin_wakeup_sel, .o_break_detect, .o_discard_rx, .o_receiver_mute);
`default_nettype wire
